// File: design/mult_div_unit.sv
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/10ps
`default_nettype none

module mult_div_unit
  import muldiv_pkg::*;
(
  input  wire logic       CLK_SYS_I,
  input  wire logic       RST_N_I,
  input  wire logic [2:0] ADDR_I,
  input  wire logic [7:0] WDATA_I,
  input  wire logic       WR_I,
  input  wire logic       RD_I,
  output logic      [7:0] RDATA_O,
  output logic            BUSY_O
);

  top_state_t r;
  top_state_t nxt;
  bus_req_t   req;
  logic       data_acc;
  logic       start;
  op_t        start_op;
  logic       eng_busy;
  logic       eng_done;
  result_t    eng_res;

  assign req      = '{wr: WR_I, rd: RD_I, addr: ADDR_I, wdata: WDATA_I};
  assign data_acc = (req.wr || req.rd) && (req.addr <= ADDR_BYTE5);

  always_comb
  begin
    nxt      = r;
    start    = 1'b0;
    start_op = OP_DIV32;
    // Read data stand only in the cycle after the read strobe
    nxt.rdata = RDATA_IDLE;

    if (eng_done)
    begin
      for (int i = 0; i < NUM_BYTES; i++)
      begin
        if (eng_res.wmask[i])
        begin
          nxt.bytes[i] = eng_res.bytes[i];
        end
      end
      nxt.ovf = eng_res.ovf;
    end

    if (eng_busy)
    begin
      // Data bytes are frozen while busy; the access only raises the error
      if (data_acc)
      begin
        nxt.err = 1'b1;
      end
      if (req.rd && (req.addr == ADDR_STATUS))
      begin
        nxt.rdata = {r.err, r.ovf, STATUS_RSVD};
      end
    end
    else if (req.wr)
    begin
      if (req.addr <= ADDR_BYTE5)
      begin
        nxt.bytes[req.addr] = req.wdata;
        // Only data writes move the order tracker; anything else leaves it
        nxt.seq = SEQ_IDLE;
        if (req.addr == ADDR_BYTE0)
        begin
          nxt.seq = SEQ_W0;
        end
        else
        begin
          case (r.seq)
            SEQ_W0:
            begin
              if (req.addr == ADDR_BYTE1)
              begin
                nxt.seq = SEQ_W01;
              end
              else if (req.addr == ADDR_BYTE4)
              begin
                nxt.seq = SEQ_W04;
              end
            end
            SEQ_W01:
            begin
              if (req.addr == ADDR_BYTE2)
              begin
                nxt.seq = SEQ_W012;
              end
              else if (req.addr == ADDR_BYTE4)
              begin
                nxt.seq = SEQ_W014;
              end
            end
            SEQ_W012:
            begin
              if (req.addr == ADDR_BYTE3)
              begin
                nxt.seq = SEQ_W0123;
              end
            end
            SEQ_W0123:
            begin
              if (req.addr == ADDR_BYTE4)
              begin
                nxt.seq = SEQ_W01234;
              end
            end
            SEQ_W01234:
            begin
              if (req.addr == ADDR_BYTE5)
              begin
                start    = 1'b1;
                start_op = OP_DIV32;
              end
            end
            SEQ_W014:
            begin
              if (req.addr == ADDR_BYTE5)
              begin
                start    = 1'b1;
                start_op = OP_DIV16;
              end
            end
            SEQ_W04:
            begin
              if (req.addr == ADDR_BYTE1)
              begin
                nxt.seq = SEQ_W041;
              end
            end
            SEQ_W041:
            begin
              if (req.addr == ADDR_BYTE5)
              begin
                start    = 1'b1;
                start_op = OP_MUL;
              end
            end
            default:
            begin
              nxt.seq = SEQ_IDLE;
            end
          endcase
        end
      end
    end
    else if (req.rd)
    begin
      if (req.addr <= ADDR_BYTE5)
      begin
        nxt.rdata = r.bytes[req.addr];
      end
      else if (req.addr == ADDR_STATUS)
      begin
        nxt.rdata = {r.err, r.ovf, STATUS_RSVD};
        nxt.err   = 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RST_N_I)
    begin
      r <= '{bytes: {NUM_BYTES{BYTE_RST}}, err: ERR_RST, ovf: OVF_RST,
             seq: SEQ_IDLE, rdata: RDATA_IDLE};
    end
    else
    begin
      r <= nxt;
    end
  end

  // Operands come from the registered bytes, which stay frozen while busy
  muldiv_engine muldiv_engine_i (
    .clk_i   (CLK_SYS_I),
    .rst_n_i (RST_N_I),
    .start_i (start),
    .op_i    (start_op),
    .opnd_i  (r.bytes),
    .busy_o  (eng_busy),
    .done_o  (eng_done),
    .res_o   (eng_res)
  );

  assign RDATA_O = r.rdata;
  assign BUSY_O  = eng_busy;

  busy_err_set_a : assert property (
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    eng_busy && (WR_I || RD_I) && (ADDR_I <= ADDR_BYTE5) |=> r.err)
    else $error("data access while busy did not set the error flag");

  err_clear_a : assert property (
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    !eng_busy && RD_I && (ADDR_I == ADDR_STATUS) |=> !r.err && RDATA_O[7] == $past(r.err))
    else $error("status read after completion did not clear the error flag");

  mul_ovf_a : assert property (
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    eng_done && (muldiv_engine_i.r.op == OP_MUL)
      |=> r.ovf == ((r.bytes[3] != 8'h00) || (r.bytes[2] != 8'h00)))
    else $error("overflow flag disagrees with the product");

  status_rsvd_a : assert property (
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    RD_I && (ADDR_I == ADDR_STATUS) |=> RDATA_O[5:0] == STATUS_RSVD)
    else $error("reserved status bits did not read as zero");

  start_w5_only_a : assert property (
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    start |-> WR_I && (ADDR_I == ADDR_BYTE5) && !eng_busy)
    else $error("calculation started without a closing byte 5 write");

  mul_order_a : assert property (
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    (r.seq == SEQ_W041) && !eng_busy && WR_I && (ADDR_I == ADDR_BYTE5)
      |-> start && (start_op == OP_MUL))
    else $error("multiply order did not start a multiplication");

  div16_order_a : assert property (
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    (r.seq == SEQ_W014) && !eng_busy && WR_I && (ADDR_I == ADDR_BYTE5)
      |-> start && (start_op == OP_DIV16))
    else $error("16/16 order did not start a division");

  div32_time_a : assert property (
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    start && (start_op == OP_DIV32) |-> ##17 (eng_done && BUSY_O) ##1 !BUSY_O)
    else $error("32/16 division did not take 17 cycles");

  mul_time_a : assert property (
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    start && (start_op == OP_MUL) |-> ##11 eng_done)
    else $error("multiplication did not take 11 cycles");

  mul_result_a : assert property (
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    eng_done && (muldiv_engine_i.r.op == OP_MUL)
      |=> {r.bytes[3], r.bytes[2], r.bytes[1], r.bytes[0]}
          == ({$past(r.bytes[1]), $past(r.bytes[0])}
              * {$past(r.bytes[5]), $past(r.bytes[4])}))
    else $error("product bytes are wrong");

  read_keeps_a : assert property (
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    RD_I && !eng_busy |=> r.bytes == $past(r.bytes) && r.seq == $past(r.seq))
    else $error("a read disturbed the data bytes or the write order");

  busy_frozen_a : assert property (
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    eng_busy && !eng_done
      |=> r.bytes == $past(r.bytes))
    else $error("data bytes changed during a calculation");

  busy_read_idle_a : assert property (
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    eng_busy && RD_I && (ADDR_I <= ADDR_BYTE5)
      |=> RDATA_O == RDATA_IDLE)
    else $error("data byte read while busy returned data");

  busy_err_keep_a : assert property (
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    eng_busy && RD_I && (ADDR_I == ADDR_STATUS) && r.err
      |=> r.err)
    else $error("status read while busy cleared the error flag");

  err_hold_a : assert property (
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    !eng_busy && !(RD_I && (ADDR_I == ADDR_STATUS))
      |=> r.err == $past(r.err))
    else $error("error flag changed without a cause");

  div_ovf_clear_a : assert property (
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    eng_done && (muldiv_engine_i.r.op != OP_MUL) && ({r.bytes[5], r.bytes[4]} != 16'h0000)
      |=> !r.ovf)
    else $error("division by a nonzero divisor raised overflow");

  ovf_hold_a : assert property (
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    !eng_done
      |=> r.ovf == $past(r.ovf))
    else $error("overflow flag changed outside completion");

  read_data_a : assert property (
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    RD_I && !eng_busy && (ADDR_I <= ADDR_BYTE5)
      |=> RDATA_O == $past(r.bytes[ADDR_I]))
    else $error("data byte read returned the wrong byte");

  order_hold_a : assert property (
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    (!WR_I || eng_busy || (ADDR_I > ADDR_BYTE5))
      |=> r.seq == $past(r.seq))
    else $error("write order moved without a data write");

  byte0_restart_a : assert property (
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    WR_I && !eng_busy && (ADDR_I == ADDR_BYTE0)
      |=> r.seq == SEQ_W0)
    else $error("byte 0 write did not restart the write order");

  div32_order_a : assert property (
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    (r.seq == SEQ_W01234) && !eng_busy && WR_I && (ADDR_I == ADDR_BYTE5)
      |-> start && (start_op == OP_DIV32))
    else $error("32/16 order did not start a division");

  div16_result_a : assert property (
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    eng_done && (muldiv_engine_i.r.op == OP_DIV16) && ({r.bytes[5], r.bytes[4]} != 16'h0000)
      |=> {r.bytes[1], r.bytes[0]}
          == ($past({r.bytes[1], r.bytes[0]}) / $past({r.bytes[5], r.bytes[4]})))
    else $error("16/16 quotient bytes are wrong");

  div32_result_a : assert property (
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    eng_done && (muldiv_engine_i.r.op == OP_DIV32) && ({r.bytes[5], r.bytes[4]} != 16'h0000)
      |=> {r.bytes[3], r.bytes[2], r.bytes[1], r.bytes[0]}
          == ($past({r.bytes[3], r.bytes[2], r.bytes[1], r.bytes[0]})
              / {16'h0000, $past({r.bytes[5], r.bytes[4]})}))
    else $error("32/16 quotient bytes are wrong");

  no_start_idle_a : assert property (
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    WR_I && !eng_busy && (ADDR_I == ADDR_BYTE5) && !start
      |=> !BUSY_O)
    else $error("a broken write order started a calculation");

endmodule : mult_div_unit

`default_nettype wire

// File: design/mdu_pkg.sv
package muldiv_pkg;

  localparam int          ADDR_W          = 3;
  localparam int          DATA_W          = 8;
  localparam int          NUM_BYTES       = 6;

  localparam logic [2:0]  ADDR_BYTE0      = 3'h0;
  localparam logic [2:0]  ADDR_BYTE1      = 3'h1;
  localparam logic [2:0]  ADDR_BYTE2      = 3'h2;
  localparam logic [2:0]  ADDR_BYTE3      = 3'h3;
  localparam logic [2:0]  ADDR_BYTE4      = 3'h4;
  localparam logic [2:0]  ADDR_BYTE5      = 3'h5;
  localparam logic [2:0]  ADDR_STATUS     = 3'h6;

  localparam int          ERR_BIT         = 7;
  localparam int          OVF_BIT         = 6;
  localparam logic [5:0]  STATUS_RSVD     = 6'h00;
  localparam logic        ERR_RST         = 1'b0;
  localparam logic        OVF_RST         = 1'b0;
  localparam logic [7:0]  BYTE_RST        = 8'h00;
  localparam logic [7:0]  RDATA_IDLE      = 8'h00;

  // Calculation times in system clock periods; one period is one clock cycle
  localparam int          DIV32_PERIODS   = 17;
  localparam int          DIV16_PERIODS   = 9;
  localparam int          MUL_PERIODS     = 11;
  localparam int          CNT_W           = 5;
  localparam logic [4:0]  DIV32_CYC       = CNT_W'(DIV32_PERIODS * 1);
  localparam logic [4:0]  DIV16_CYC       = CNT_W'(DIV16_PERIODS * 1);
  localparam logic [4:0]  MUL_CYC         = CNT_W'(MUL_PERIODS * 1);

  localparam logic [15:0] MUL_LIMIT       = 16'hFFFF;
  localparam logic [31:0] DIV0_QUOT       = 32'hFFFFFFFF;
  localparam logic [5:0]  MASK_DIV32      = 6'h3F;
  localparam logic [5:0]  MASK_DIV16      = 6'h33;
  localparam logic [5:0]  MASK_MUL        = 6'h0F;

  typedef enum logic [1:0] {OP_DIV32, OP_DIV16, OP_MUL} op_t;

  typedef enum logic [3:0] {
    SEQ_IDLE, SEQ_W0, SEQ_W01, SEQ_W012, SEQ_W0123, SEQ_W01234,
    SEQ_W014, SEQ_W04, SEQ_W041
  } seq_t;

  typedef logic [NUM_BYTES-1:0][7:0] byte_file_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } bus_req_t;

  typedef struct packed {
    byte_file_t bytes;
    logic [5:0] wmask;
    logic       ovf;
  } result_t;

  typedef struct packed {
    logic [4:0] cnt;
    op_t        op;
  } eng_state_t;

  typedef struct packed {
    byte_file_t bytes;
    logic       err;
    logic       ovf;
    seq_t       seq;
    logic [7:0] rdata;
  } top_state_t;

endpackage : muldiv_pkg

// File: design/mdu_engine.sv
`timescale 1ns/10ps
`default_nettype none

module muldiv_engine
  import muldiv_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       start_i,
  input  wire op_t        op_i,
  input  wire byte_file_t opnd_i,
  output logic            busy_o,
  output logic            done_o,
  output result_t         res_o
);

  eng_state_t  r;
  eng_state_t  nxt;
  logic [31:0] dividend32;
  logic [15:0] dividend16;
  logic [15:0] divisor;
  logic [31:0] product;
  logic [31:0] quot32;
  logic [31:0] rem32;

  always_comb
  begin
    nxt = r;
    if (start_i)
    begin
      nxt.op = op_i;
      case (op_i)
        OP_DIV32: nxt.cnt = DIV32_CYC;
        OP_DIV16: nxt.cnt = DIV16_CYC;
        default:  nxt.cnt = MUL_CYC;
      endcase
    end
    else if (r.cnt != 5'h00)
    begin
      nxt.cnt = r.cnt - 5'h01;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      r <= '{cnt: 5'h00, op: OP_DIV32};
    end
    else
    begin
      r <= nxt;
    end
  end

  assign busy_o = (r.cnt != 5'h00);
  assign done_o = (r.cnt == 5'h01);

  // Operands are frozen while busy, so the result is formed in the last cycle
  always_comb
  begin
    dividend16 = {opnd_i[1], opnd_i[0]};
    dividend32 = {opnd_i[3], opnd_i[2], opnd_i[1], opnd_i[0]};
    divisor    = {opnd_i[5], opnd_i[4]};
    product    = 32'h00000000;
    quot32     = 32'h00000000;
    rem32      = 32'h00000000;
    res_o      = '0;
    case (r.op)
      OP_DIV32:
      begin
        res_o.wmask = MASK_DIV32;
        if (divisor == 16'h0000)
        begin
          quot32    = DIV0_QUOT;
          rem32     = {16'h0000, dividend32[15:0]};
          res_o.ovf = 1'b1;
        end
        else
        begin
          quot32 = dividend32 / {16'h0000, divisor};
          rem32  = dividend32 % {16'h0000, divisor};
        end
        res_o.bytes = {rem32[15:0], quot32};
      end
      OP_DIV16:
      begin
        res_o.wmask = MASK_DIV16;
        if (divisor == 16'h0000)
        begin
          quot32    = {16'h0000, DIV0_QUOT[15:0]};
          rem32     = {16'h0000, dividend16};
          res_o.ovf = 1'b1;
        end
        else
        begin
          quot32 = {16'h0000, dividend16 / divisor};
          rem32  = {16'h0000, dividend16 % divisor};
        end
        res_o.bytes = {rem32[15:0], 16'h0000, quot32[15:0]};
      end
      default:
      begin
        res_o.wmask = MASK_MUL;
        product     = {16'h0000, dividend16} * {16'h0000, divisor};
        res_o.bytes = {16'h0000, product};
        res_o.ovf   = (product > {16'h0000, MUL_LIMIT});
      end
    endcase
  end

  div_zero_ovf_a : assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    done_o && (r.op != OP_MUL) && (opnd_i[5] == 8'h00) && (opnd_i[4] == 8'h00)
      |-> res_o.ovf)
    else $error("divide by zero did not raise overflow");

  div16_time_a : assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    start_i && (op_i == OP_DIV16) |-> ##1 (busy_o && !done_o)[*8] ##1 done_o)
    else $error("16/16 division did not take 9 cycles");

endmodule : muldiv_engine

`default_nettype wire

// File: verif/cpu_model.sv
`timescale 1ns/10ps
`default_nettype none

module cpu_model
(
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  output logic      [2:0] addr_o,
  output logic      [7:0] wdata_o,
  output logic            wr_o,
  output logic            rd_o
);
  initial
  begin
    addr_o  = 3'h7;
    wdata_o = 8'h00;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end

  // Released lines show the inverse so a stale value never passes for a fresh one
  task automatic write_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge clk_i);
    addr_o  <= ~a;
    wdata_o <= ~d;
    wr_o    <= 1'b0;
  endtask : write_reg

  // Read data stand only in the cycle after the strobe, so sample mid-cycle there
  task automatic read_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge clk_i);
    addr_o <= ~a;
    rd_o   <= 1'b0;
    @(negedge clk_i);
    d = rdata_i;
  endtask : read_reg
endmodule : cpu_model

`default_nettype wire

// File: verif/tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_top
  import muldiv_pkg::*;
;
  logic       clk;
  logic       rst_n;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       busy;
  logic [7:0] rv;
  int         bad_count;
  int         checks;
  int         cycles;

  always #20 clk = ~clk;

  mult_div_unit mult_div_unit_i (
    .CLK_SYS_I (clk),
    .RST_N_I   (rst_n),
    .ADDR_I    (addr),
    .WDATA_I   (wdata),
    .WR_I      (wr),
    .RD_I      (rd),
    .RDATA_O   (rdata),
    .BUSY_O    (busy)
  );

  cpu_model cpu_model_i (
    .clk_i   (clk),
    .rdata_i (rdata),
    .addr_o  (addr),
    .wdata_o (wdata),
    .wr_o    (wr),
    .rd_o    (rd)
  );

  task automatic give_verdict();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      bad_count++;
      give_verdict();
    end
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
    cpu_model_i.read_reg(a, rv);
    chk($sformatf("register %0d", a), exp, rv);
  endtask : rd_chk

  // Counts busy cycles after a write, bounded against a hang
  task automatic wait_idle(output logic [7:0] n);
    n = 8'h00;
    @(negedge clk);
    while (busy === 1'b1 && n < 8'h40)
    begin
      n++;
      @(negedge clk);
    end
  endtask : wait_idle

  task automatic do_op(input op_t op, input logic [31:0] a, input logic [15:0] b);
    logic [31:0] q;
    logic [15:0] r;
    logic        ov;
    logic [7:0]  n;
    logic [7:0]  cyc;
    cpu_model_i.write_reg(ADDR_BYTE0, a[7:0]);
    cpu_model_i.read_reg(ADDR_STATUS, rv);
    if (op == OP_MUL)
    begin
      cpu_model_i.write_reg(ADDR_BYTE4, b[7:0]);
      cpu_model_i.write_reg(ADDR_BYTE1, a[15:8]);
    end
    else
    begin
      cpu_model_i.write_reg(ADDR_BYTE1, a[15:8]);
      if (op == OP_DIV32)
      begin
        cpu_model_i.write_reg(ADDR_BYTE2, a[23:16]);
        cpu_model_i.write_reg(ADDR_BYTE3, a[31:24]);
      end
      cpu_model_i.write_reg(ADDR_BYTE4, b[7:0]);
    end
    cpu_model_i.write_reg(ADDR_BYTE5, b[15:8]);
    wait_idle(n);
    ov = (b == 16'h0000);
    r  = a[15:0];
    if (op == OP_MUL)
    begin
      q   = a[15:0] * b;
      ov  = (q > 32'h0000FFFF);
      cyc = 8'(MUL_PERIODS);
    end
    else if (op == OP_DIV16)
    begin
      q   = ov ? 32'h0000FFFF : 32'(a[15:0] / b);
      r   = ov ? a[15:0] : 16'(a[15:0] % b);
      cyc = 8'(DIV16_PERIODS);
    end
    else
    begin
      q   = ov ? 32'hFFFFFFFF : a / b;
      r   = ov ? a[15:0] : 16'(a % b);
      cyc = 8'(DIV32_PERIODS);
    end
    chk("busy cycles", cyc, n);
    rd_chk(ADDR_STATUS, {1'b0, ov, 6'h00});
    rd_chk(ADDR_BYTE0, q[7:0]);
    rd_chk(ADDR_BYTE1, q[15:8]);
    if (op != OP_DIV16)
    begin
      rd_chk(ADDR_BYTE2, q[23:16]);
      rd_chk(ADDR_BYTE3, q[31:24]);
    end
    if (op != OP_MUL)
    begin
      rd_chk(ADDR_BYTE4, r[7:0]);
      rd_chk(ADDR_BYTE5, r[15:8]);
    end
  endtask : do_op

  task automatic busy_access();
    logic [7:0] n;
    cpu_model_i.write_reg(ADDR_BYTE0, 8'h34);
    cpu_model_i.write_reg(ADDR_BYTE4, 8'h02);
    cpu_model_i.write_reg(ADDR_BYTE1, 8'h12);
    cpu_model_i.write_reg(ADDR_BYTE5, 8'h00);
    rd_chk(ADDR_BYTE0, 8'h00);
    cpu_model_i.write_reg(ADDR_BYTE2, 8'h55);
    rd_chk(ADDR_STATUS, 8'h80);
    wait_idle(n);
    rd_chk(ADDR_STATUS, 8'h80);
    rd_chk(ADDR_STATUS, 8'h00);
    rd_chk(ADDR_BYTE0, 8'h68);
    rd_chk(ADDR_BYTE2, 8'h00);
  endtask : busy_access

  task automatic bad_order();
    logic [7:0] n;
    do_op(OP_DIV16, 32'h0000ABCD, 16'h0000);
    cpu_model_i.write_reg(ADDR_BYTE0, 8'h11);
    cpu_model_i.write_reg(ADDR_BYTE4, 8'h22);
    cpu_model_i.write_reg(ADDR_BYTE5, 8'h33);
    wait_idle(n);
    chk("busy cycles", 8'h00, n);
    rd_chk(ADDR_STATUS, 8'h40);
    rd_chk(ADDR_BYTE5, 8'h33);
  endtask : bad_order

  initial
  begin
    clk       = 1'b0;
    rst_n     = 1'b0;
    bad_count = 0;
    checks    = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rd_chk(ADDR_STATUS, 8'h00);
    cpu_model_i.write_reg(3'h7, 8'hFF);
    rd_chk(3'h7, 8'h00);
    rd_chk(ADDR_STATUS, 8'h00);
    busy_access();
    do_op(OP_DIV32, 32'h12345678, 16'h1234);
    do_op(OP_DIV32, 32'hFFFFFFFF, 16'h0001);
    do_op(OP_MUL, 32'h0000FFFF, 16'hFFFF);
    bad_order();
    do_op(OP_MUL, 32'h0000ABCD, 16'h0001);
    do_op(OP_DIV16, 32'h0000FFFF, 16'h0010);
    do_op(OP_DIV32, 32'h00050000, 16'h0000);
    give_verdict();
  end
endmodule : tb_top

`default_nettype wire
